// ---- src/cisd_pkg.sv ----
// shared constants and types for the instruction subset decoder
package cisd_pkg;

    // word and field widths
    localparam int INSN_W   = 14;
    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 7;
    localparam int PC_W     = 13;
    localparam int CALL_W   = 11;

    // opcode patterns
    localparam logic [5:0] OP_AND_LIT   = 6'h39; // 11 1001
    localparam logic [5:0] OP_AND_WF    = 6'h05; // 00 0101
    localparam logic [5:0] OP_ADD_WF    = 6'h07; // 00 0111
    localparam logic [6:0] OP_CLR_F     = 7'h03; // 00 0001 1
    localparam logic [3:0] OP_BIT_SKIP  = 4'h7;  // 01 11
    localparam logic [2:0] OP_CALL      = 3'h4;  // 10 0

    // field positions
    localparam int DEST_POS  = 7;
    localparam int BIT_LSB   = 7;
    localparam int LATCH_LSB = 3;

    // reset values
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;

    // execution phases
    typedef enum logic [1:0] {
        CISD_EXEC,
        CISD_FLUSH
    } cisd_state_t;

endpackage

// ---- src/cisd_alu.sv ----
// combinational alu for and/add/clear with flag results
`timescale 1ns/10ps
`default_nettype none

module cisd_alu #(
    parameter int DATA_W = 8
) (
    // operands and operation select
    input  wire logic [DATA_W-1:0] work_val,
    input  wire logic [DATA_W-1:0] operand,
    input  wire logic              do_add,
    input  wire logic              do_clear,
    // result and flags
    output logic [DATA_W-1:0]      result,
    output logic                   carry,
    output logic                   digit_carry,
    output logic                   zero
);

    logic [DATA_W:0] sum;
    logic [4:0]      low_sum;

    // sum, nibble sum and zero detect
    always_comb
    begin
        sum     = {1'b0, work_val} + {1'b0, operand};
        low_sum = {1'b0, work_val[3:0]} + {1'b0, operand[3:0]};
        if (do_clear)
            result = '0;
        else if (do_add)
            result = sum[DATA_W-1:0];
        else
            result = work_val & operand;
        carry       = sum[DATA_W];
        digit_carry = low_sum[4];
        zero        = (result == '0);
    end

endmodule
`default_nettype wire

// ---- src/cisd_core.sv ----
// instruction subset decoder and executor
`timescale 1ns/10ps
`default_nettype none

module cisd_core #(
    parameter int INSN_W  = cisd_pkg::INSN_W,
    parameter int DATA_W  = cisd_pkg::DATA_W,
    parameter int FADDR_W = cisd_pkg::FADDR_W,
    parameter int PC_W    = cisd_pkg::PC_W
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // instruction fetch
    input  wire logic [INSN_W-1:0]  insn,
    input  wire logic               insn_valid,
    output logic [PC_W-1:0]         pc,
    // file register access
    output logic [FADDR_W-1:0]      file_addr,
    input  wire logic [DATA_W-1:0]  file_rdata,
    output logic [DATA_W-1:0]       file_wdata,
    output logic                    file_we,
    // upper latch and stack
    input  wire logic [4:0]         pc_upper_latch,
    output logic [PC_W-1:0]         stack_push_data,
    output logic                    stack_push,
    // visible core state
    output logic [DATA_W-1:0]       work,
    output logic                    zero_flag,
    output logic                    carry_flag,
    output logic                    digit_carry_flag,
    output logic                    flush
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // execution state, declared ahead of the decode that reads it
    cisd_pkg::cisd_state_t state_reg;
    cisd_pkg::cisd_state_t state_next;
    logic [PC_W-1:0]       pc_reg;
    logic [PC_W-1:0]       pc_next;
    logic [DATA_W-1:0]     work_reg;
    logic [DATA_W-1:0]     work_next;
    logic                  z_reg;
    logic                  z_next;
    logic                  c_reg;
    logic                  c_next;
    logic                  dc_reg;
    logic                  dc_next;
    logic [PC_W-1:0]       push_reg;
    logic [PC_W-1:0]       push_next;
    logic                  push_v_reg;
    logic                  push_v_next;
    logic [DATA_W-1:0]     wdata_reg;
    logic [DATA_W-1:0]     wdata_next;
    logic                  we_reg;
    logic                  we_next;

    logic [5:0]         op6;
    logic               is_and_lit;
    logic               is_and_wf;
    logic               is_add_wf;
    logic               is_clr_f;
    logic               is_bit_skip;
    logic               is_call;
    logic               dest_file;
    logic [2:0]         bit_sel;
    logic [DATA_W-1:0]  alu_res;
    logic               alu_c;
    logic               alu_dc;
    logic               alu_z;
    logic               do_exec;

    // opcode fields out of the 14-bit word
    always_comb
    begin
        op6         = insn[INSN_W-1 -: 6];
        is_and_lit  = (op6 == cisd_pkg::OP_AND_LIT);
        is_and_wf   = (op6 == cisd_pkg::OP_AND_WF);
        is_add_wf   = (op6 == cisd_pkg::OP_ADD_WF);
        is_clr_f    = (insn[INSN_W-1 -: 7] == cisd_pkg::OP_CLR_F);
        is_bit_skip = (insn[INSN_W-1 -: 4] == cisd_pkg::OP_BIT_SKIP);
        is_call     = (insn[INSN_W-1 -: 3] == cisd_pkg::OP_CALL);
        dest_file   = insn[cisd_pkg::DEST_POS];
        bit_sel     = insn[cisd_pkg::BIT_LSB +: 3];
        file_addr   = insn[FADDR_W-1:0];
        do_exec     = insn_valid && (state_reg == cisd_pkg::CISD_EXEC);
    end

    // shared alu
    cisd_alu #(
        .DATA_W      (DATA_W)
    ) u_alu (
        .work_val    (work_reg),
        .operand     (is_and_lit ? insn[DATA_W-1:0] : file_rdata),
        .do_add      (is_add_wf),
        .do_clear    (is_clr_f),
        .result      (alu_res),
        .carry       (alu_c),
        .digit_carry (alu_dc),
        .zero        (alu_z)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    // next-state and execute
    always_comb
    begin
        state_next  = state_reg;
        pc_next     = pc_reg;
        work_next   = work_reg;
        z_next      = z_reg;
        c_next      = c_reg;
        dc_next     = dc_reg;
        push_next   = push_reg;
        push_v_next = 1'b0;
        wdata_next  = wdata_reg;
        we_next     = 1'b0;
        case (state_reg)
            cisd_pkg::CISD_EXEC:
            begin
                if (insn_valid)
                begin
                    pc_next = pc_reg + 13'h0001;
                    if (is_and_lit)
                    begin
                        work_next = alu_res;
                        z_next    = alu_z;
                    end
                    else if (is_and_wf || is_add_wf)
                    begin
                        z_next = alu_z;
                        if (is_add_wf)
                        begin
                            c_next  = alu_c;
                            dc_next = alu_dc;
                        end
                        if (dest_file)
                        begin
                            wdata_next = alu_res;
                            we_next    = 1'b1;
                        end
                        else
                            work_next = alu_res;
                    end
                    else if (is_clr_f)
                    begin
                        wdata_next = '0;
                        we_next    = 1'b1;
                        z_next     = 1'b1;
                    end
                    else if (is_bit_skip)
                    begin
                        if (file_rdata[bit_sel])
                        begin
                            pc_next    = pc_reg + 13'h0002;
                            state_next = cisd_pkg::CISD_FLUSH;
                        end
                    end
                    else if (is_call)
                    begin
                        push_next   = pc_reg + 13'h0001;
                        push_v_next = 1'b1;
                        pc_next     = {pc_upper_latch[4:cisd_pkg::LATCH_LSB],
                                       insn[cisd_pkg::CALL_W-1:0]};
                        state_next  = cisd_pkg::CISD_FLUSH;
                    end
                end
            end
            cisd_pkg::CISD_FLUSH:
                state_next = cisd_pkg::CISD_EXEC;
            default:
                state_next = cisd_pkg::CISD_EXEC;
        endcase
    end

    // register update
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= cisd_pkg::CISD_EXEC;
            pc_reg     <= cisd_pkg::PC_RST;
            work_reg   <= cisd_pkg::WORK_RST;
            z_reg      <= 1'b0;
            c_reg      <= 1'b0;
            dc_reg     <= 1'b0;
            push_reg   <= '0;
            push_v_reg <= 1'b0;
            wdata_reg  <= '0;
            we_reg     <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            pc_reg     <= pc_next;
            work_reg   <= work_next;
            z_reg      <= z_next;
            c_reg      <= c_next;
            dc_reg     <= dc_next;
            push_reg   <= push_next;
            push_v_reg <= push_v_next;
            wdata_reg  <= wdata_next;
            we_reg     <= we_next;
        end
    end

    // outputs
    assign pc               = pc_reg;
    assign work             = work_reg;
    assign zero_flag        = z_reg;
    assign carry_flag       = c_reg;
    assign digit_carry_flag = dc_reg;
    assign stack_push_data  = push_reg;
    assign stack_push       = push_v_reg;
    assign file_wdata       = wdata_reg;
    assign file_we          = we_reg;
    assign flush            = (state_reg == cisd_pkg::CISD_FLUSH);

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_skip_taken;
        do_exec && is_bit_skip && file_rdata[bit_sel];
    endsequence

    sequence s_call_issue;
        do_exec && is_call;
    endsequence

    property p_and_lit;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && is_and_lit) |=> work == ($past(work) & $past(insn[7:0]));
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

    property p_and_wf_keep_c;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && is_and_wf) |=> $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_and_wf_keep_c: assert property (p_and_wf_keep_c) else $error("and changed c");

    property p_add_dest;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && is_add_wf && dest_file) |=> file_we && $stable(work);
    endproperty
    a_add_dest: assert property (p_add_dest) else $error("add dest wrong");

    property p_skip_flags;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && is_bit_skip) |=> $stable(zero_flag) && $stable(carry_flag);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip touched flags");

    property p_skip_flush;
        @(posedge clk_sys) disable iff (rst)
        s_skip_taken |=> flush ##1 !flush;
    endproperty
    a_skip_flush: assert property (p_skip_flush) else $error("skip not two cycles");

    property p_call_push;
        @(posedge clk_sys) disable iff (rst)
        s_call_issue |=> stack_push && stack_push_data == $past(pc) + 13'h0001 && flush;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_upper;
        @(posedge clk_sys) disable iff (rst)
        s_call_issue |=> pc[12:11] == $past(pc_upper_latch[4:3]);
    endproperty
    a_call_upper: assert property (p_call_upper) else $error("call upper wrong");

    property p_clear;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && is_clr_f) |=> file_we && file_wdata == 8'h00 && zero_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong");

    property p_zero;
        @(posedge clk_sys) disable iff (rst)
        (do_exec && (is_and_wf || is_add_wf) && !dest_file) |=> zero_flag == (work == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule
`default_nettype wire

// ---- tb/cisd_core_tb_top.sv ----
// self-checking testbench for the instruction subset decoder core
`timescale 1ns/10ps
`default_nettype none

module cisd_core_tb_top;

    ////////////////////////////////////////////////////////////////////////
    // design signals
    logic        clk_sys;
    logic        rst;
    logic [13:0] insn;
    logic        insn_valid;
    logic [12:0] pc;
    logic [6:0]  file_addr;
    logic [7:0]  file_rdata;
    logic [7:0]  file_wdata;
    logic        file_we;
    logic [4:0]  pc_upper_latch;
    logic [12:0] stack_push_data;
    logic        stack_push;
    logic [7:0]  work;
    logic        zero_flag;
    logic        carry_flag;
    logic        digit_carry_flag;
    logic        flush;

    // bench bookkeeping and expected core state
    int          fails;
    int          checks_done;
    logic [12:0] exp_pc;
    logic [7:0]  exp_work;
    logic        exp_z;
    logic        exp_c;
    logic        exp_dc;

    cisd_core dut (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .insn             (insn),
        .insn_valid       (insn_valid),
        .pc               (pc),
        .file_addr        (file_addr),
        .file_rdata       (file_rdata),
        .file_wdata       (file_wdata),
        .file_we          (file_we),
        .pc_upper_latch   (pc_upper_latch),
        .stack_push_data  (stack_push_data),
        .stack_push       (stack_push),
        .work             (work),
        .zero_flag        (zero_flag),
        .carry_flag       (carry_flag),
        .digit_carry_flag (digit_carry_flag),
        .flush            (flush)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock generation
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    // compare one value and count it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // report counts, verdict, end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // compare visible core state with the expectation
    task automatic check_state;
        check(16'(work), 16'(exp_work));
        check(16'(zero_flag), 16'(exp_z));
        check(16'(carry_flag), 16'(exp_c));
        check(16'(digit_carry_flag), 16'(exp_dc));
        check(16'(pc), 16'(exp_pc));
    endtask

    // present one word at a rising edge
    task automatic drive(input logic [13:0] word, input logic [7:0] rdata);
        @(posedge clk_sys);
        insn       <= word;
        insn_valid <= 1'b1;
        file_rdata <= rdata;
    endtask

    // drop the request at the next rising edge
    task automatic idle;
        @(posedge clk_sys);
        insn_valid <= 1'b0;
        insn       <= 14'h0000;
    endtask

    // one single-cycle instruction, with file write expectation
    task automatic run(input logic [13:0] word, input logic [7:0] rdata,
                       input logic we, input logic [7:0] wdata);
        drive(word, rdata);
        #1;
        check(16'(file_addr), 16'(word[6:0]));
        idle();
        #1;
        exp_pc = exp_pc + 13'h0001;
        check(16'(file_we), 16'(we));
        if (we)
            check(16'(file_wdata), 16'(wdata));
        check(16'(flush), 16'h0000);
        check_state();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenario: state right after reset
    task automatic t_reset;
        exp_pc = 13'h0000;
        exp_work = 8'h00;
        {exp_z, exp_c, exp_dc} = 3'h0;
        check_state();
        check(16'(file_we), 16'h0000);
        check(16'(stack_push), 16'h0000);
    endtask

    // scenario: add, and, clear chain with flag side effects
    task automatic t_alu;
        exp_work = 8'hc2;
        run({cisd_pkg::OP_ADD_WF, 1'b0, 7'h10}, 8'hc2, 1'b0, 8'h00);
        exp_work = 8'hd9;
        run({cisd_pkg::OP_ADD_WF, 1'b0, 7'h10}, 8'h17, 1'b0, 8'h00);
        exp_work = 8'ha3;
        {exp_c, exp_dc} = 2'h3;
        run({cisd_pkg::OP_ADD_WF, 1'b0, 7'h10}, 8'hca, 1'b0, 8'h00);
        exp_work = 8'h03;
        run({cisd_pkg::OP_AND_LIT, 8'h5f}, 8'h00, 1'b0, 8'h00);
        exp_z = 1'b1;
        run({cisd_pkg::OP_ADD_WF, 1'b1, 7'h2a}, 8'hfd, 1'b1, 8'h00);
        exp_z = 1'b0;
        run({cisd_pkg::OP_AND_WF, 1'b1, 7'h7f}, 8'h02, 1'b1, 8'h02);
        exp_z = 1'b1;
        run({cisd_pkg::OP_CLR_F, 7'h7f}, 8'h55, 1'b1, 8'h00);
        exp_work = 8'h00;
        run({cisd_pkg::OP_AND_WF, 1'b0, 7'h01}, 8'h0c, 1'b0, 8'h00);
        @(posedge clk_sys);
        #1;
        check(16'(file_we), 16'h0000);
    endtask

    // scenario: bit test skip, not taken then taken with discarded word
    task automatic t_skip;
        run({cisd_pkg::OP_BIT_SKIP, 3'h3, 7'h05}, 8'hf7, 1'b0, 8'h00);
        drive({cisd_pkg::OP_BIT_SKIP, 3'h7, 7'h05}, 8'h80);
        drive({cisd_pkg::OP_ADD_WF, 1'b0, 7'h10}, 8'h44);
        #1;
        exp_pc = exp_pc + 13'h0002;
        check(16'(flush), 16'h0001);
        check_state();
        idle();
        #1;
        check(16'(flush), 16'h0000);
        check_state();
    endtask

    // scenario: call with upper latch bits and return address push
    task automatic t_call;
        logic [12:0] ret;
        ret = exp_pc + 13'h0001;
        pc_upper_latch <= 5'h18;
        drive({cisd_pkg::OP_CALL, 11'h5a5}, 8'h00);
        idle();
        #1;
        exp_pc = {2'h3, 11'h5a5};
        check(16'(stack_push), 16'h0001);
        check(16'(stack_push_data), 16'(ret));
        check(16'(flush), 16'h0001);
        check(16'(pc), 16'(exp_pc));
        check_state();
        @(posedge clk_sys);
        #1;
        check(16'(stack_push), 16'h0000);
        check(16'(flush), 16'h0000);
        check_state();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        fails = 0;
        checks_done = 0;
        rst = 1'b1;
        insn = 14'h0000;
        insn_valid = 1'b0;
        file_rdata = 8'h00;
        pc_upper_latch = 5'h00;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        t_reset();
        t_alu();
        t_skip();
        t_call();
        close_out();
    end

    // watchdog against a hung run
    initial
    begin
        #50000;
        fails++;
        close_out();
    end

endmodule

`default_nettype wire
